// ===== design/lpmf_pkg.sv
// Package: constants, types and helpers for the link packet match filter
package lpmf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_MATCH_LOW   = 8'h00; // Pair base + 0x0
  localparam logic [7:0] OFF_MATCH_HIGH  = 8'h04; // Pair base + 0x4
  localparam logic [7:0] OFF_MASK_LOW    = 8'h08; // Pair base + 0x8
  localparam logic [7:0] OFF_MASK_HIGH   = 8'h0C; // Pair base + 0xC
  localparam logic [7:0] PAIR_STRIDE     = 8'h10; // Second pair at 0x10
  localparam logic [7:0] OFF_CTL_BASE    = 8'h20; // Counter control i
  localparam logic [7:0] OFF_CTR_BASE    = 8'h30; // Counter data i
  localparam logic [7:0] CTR_STRIDE      = 8'h08; // Low word, high word
  localparam logic [7:0] OFF_STATUS      = 8'h50; // Last packet status
  localparam logic [7:0] ADDR_LIMIT      = 8'h54; // First unmapped byte

  // ----------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [31:0] FILT_RESET     = 32'h0000_0000;
  localparam logic [31:0] CTL_RESET      = 32'h0000_0000;
  localparam logic [31:0] HIGH_WR_MASK   = 32'h000F_000F; // 19:16, 3:0
  localparam logic [31:0] LOW_WR_MASK    = 32'h8003_FFF8; // 31, 17:3
  localparam logic [31:0] CTL_WR_MASK    = 32'hFF75_FFFF; // No 23,19,17

  // ----------------------------------------------------------------
  // Filter word field positions
  // ----------------------------------------------------------------
  localparam int STATE_LSB     = 16; // High word 19:16
  localparam int RNID_LOW_LSB  = 0;  // High word 3:0
  localparam int RNID_TOP_BIT  = 31; // Low word 31
  localparam int DEST_LSB      = 13; // Low word 17:13
  localparam int CLASS_LSB     = 9;  // Low word 12:9
  localparam int OPCODE_LSB    = 5;  // Low word 8:5
  localparam int VN_LSB        = 3;  // Low word 4:3

  // ----------------------------------------------------------------
  // Counter control fields and sizes
  // ----------------------------------------------------------------
  localparam int          CTL_EN_BIT     = 22;
  localparam int          CTL_CLR_BIT    = 17;
  localparam int          CTL_PAIR_BIT   = 8;  // Lowest subevent bit
  localparam logic [7:0]  EVSEL_FILTER_MATCH = 8'h38;
  localparam int          CTR_WIDTH      = 48;
  localparam int          NUM_PAIRS      = 2;

  // ----------------------------------------------------------------
  // Message classes, data states, virtual networks
  // ----------------------------------------------------------------
  localparam logic [3:0] CLASS_HOME_REQ     = 4'h0;
  localparam logic [3:0] CLASS_HOME_RSP     = 4'h1;
  localparam logic [3:0] CLASS_NON_DATA_RSP = 4'h2;
  localparam logic [3:0] CLASS_SNOOP        = 4'h3;
  localparam logic [3:0] CLASS_NC_STANDARD  = 4'h4;
  localparam logic [3:0] CLASS_NC_BYPASS    = 4'hC;
  localparam logic [3:0] CLASS_DATA_RSP     = 4'hE;
  localparam logic [3:0] OPCODE_STATE_MAX   = 4'h2;
  localparam logic [3:0] STATE_MODIFIED     = 4'h8;
  localparam logic [3:0] STATE_EXCLUSIVE    = 4'h4;
  localparam logic [3:0] STATE_SHARED       = 4'h2;
  localparam logic [3:0] STATE_FORWARDING   = 4'h1;
  localparam logic [3:0] STATE_INVALID      = 4'h0;
  localparam logic [1:0] VN_FIRST        = 2'h0;
  localparam logic [1:0] VN_SECOND       = 2'h1;

  // Packet sizes in flits
  localparam logic [3:0] FLITS_FULL      = 4'h9;
  localparam logic [3:0] FLITS_PARTIAL   = 4'hB;
  localparam logic [3:0] FLITS_STD_SHORT = 4'h2;
  localparam logic [3:0] FLITS_STD_LONG  = 4'h3;
  localparam logic [3:0] FLITS_UNKNOWN   = 4'h0;

  // ----------------------------------------------------------------
  // Packet header as seen on the serviced path
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] response_data_state;
    logic [4:0] remote_node_id;
    logic [4:0] destination_node_id;
    logic [3:0] message_class;
    logic [3:0] packet_opcode;
    logic [1:0] virtual_network;
  } lpmf_hdr_t;

  // Header placed into the high filter word layout
  function automatic logic [31:0] hdr_high(input lpmf_hdr_t h);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[STATE_LSB +: 4]    = h.response_data_state;
    w[RNID_LOW_LSB +: 4] = h.remote_node_id[3:0];
    return w;
  endfunction : hdr_high

  // Header placed into the low filter word layout
  function automatic logic [31:0] hdr_low(input lpmf_hdr_t h);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[RNID_TOP_BIT]  = h.remote_node_id[4];
    w[DEST_LSB +: 5]   = h.destination_node_id;
    w[CLASS_LSB +: 4]  = h.message_class;
    w[OPCODE_LSB +: 4] = h.packet_opcode;
    w[VN_LSB +: 2]   = h.virtual_network;
    return w;
  endfunction : hdr_low

  // Packet length from class and opcode size bit
  function automatic logic [3:0] packet_flits(input lpmf_hdr_t h);
    logic [3:0] f;
    f = FLITS_UNKNOWN;
    if ((h.message_class == CLASS_DATA_RSP)
        || (h.message_class == CLASS_NC_BYPASS))
      f = h.packet_opcode[3] ? FLITS_PARTIAL : FLITS_FULL;
    else if (h.message_class == CLASS_NC_STANDARD)
      f = h.packet_opcode[3] ? FLITS_STD_LONG : FLITS_STD_SHORT;
    return f;
  endfunction : packet_flits

endpackage : lpmf_pkg

// ===== design/lpmf_match.sv
// Module: one match/mask pair compared against a packet header
`timescale 1ns/10ps
`default_nettype none
module lpmf_match
  import lpmf_pkg::*;
(
  input  wire lpmf_hdr_t   hdr,        // Serviced packet header
  input  wire logic [31:0] match_low,  // Match word, low layout
  input  wire logic [31:0] match_high, // Match word, high layout
  input  wire logic [31:0] mask_low,   // Mask word, low layout
  input  wire logic [31:0] mask_high,  // Mask word, high layout
  output logic             hit         // Header satisfies the pair
);

  // ----------------------------------------------------------------
  // Masked comparison
  // ----------------------------------------------------------------
  logic [31:0] eff_mask_high; // High mask after data state gating
  logic        state_valid;   // Data state meaningful for packet

  // Compare only where mask bits are one
  always_comb
  begin
    state_valid = (hdr.message_class == CLASS_DATA_RSP)
                  && (hdr.packet_opcode <= OPCODE_STATE_MAX);
    eff_mask_high = mask_high & HIGH_WR_MASK;
    // Drop the data state mask when the field carries no meaning
    if (!state_valid)
      eff_mask_high[STATE_LSB +: 4] = 4'h0;
    hit = (((hdr_low(hdr) ^ match_low) & mask_low & LOW_WR_MASK)
           == 32'h0000_0000)
          && (((hdr_high(hdr) ^ match_high) & eff_mask_high)
              == 32'h0000_0000);
  end

endmodule : lpmf_match
`default_nettype wire

// ===== design/lpmf_counter.sv
// Module: one wrapping performance counter with word loads
`timescale 1ns/10ps
`default_nettype none
module lpmf_counter
  import lpmf_pkg::*;
#(
  parameter int WIDTH = CTR_WIDTH // Counter width in bits
)
(
  input  wire logic             clk,      // Link layer clock
  input  wire logic             rst,      // Synchronous reset
  input  wire logic             clear,    // Clear to zero
  input  wire logic             load_low, // Load bits 31:0
  input  wire logic             load_high,// Load bits WIDTH-1:32
  input  wire logic [31:0]      wdata,    // Load data
  input  wire logic             inc,      // Count one event
  output logic [WIDTH-1:0]      count_q   // Current count
);

  logic [WIDTH-1:0] count_d; // Next count

  // ----------------------------------------------------------------
  // Next count: clear, then load, then increment
  // ----------------------------------------------------------------
  always_comb
  begin
    count_d = count_q;
    if (clear)
      count_d = '0;
    else if (load_low)
      count_d[31:0] = wdata;
    else if (load_high)
      count_d[WIDTH-1:32] = wdata[WIDTH-33:0];
    else if (inc)
      // carry out of top bit wraps
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  // Register only
  always_ff @(posedge clk)
  begin
    if (rst)
      count_q <= '0;
    else
      count_q <= count_d;
  end

endmodule : lpmf_counter
`default_nettype wire

// ===== design/lpmf_top.sv
// Module: link port packet filter with counters and APB registers
`timescale 1ns/10ps
`default_nettype none
module lpmf_top
  import lpmf_pkg::*;
#(
  parameter int NUM_CTR = 4 // Counters on this port
)
(
  input  wire logic        clk,        // Link layer clock, 125 MHz
  input  wire logic        rst,        // Synchronous reset, high
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB write
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic [31:0]      prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error
  input  wire logic        pkt_valid,  // Header valid at input port
  input  wire logic        pkt_accept, // Output port takes packet
  input  wire lpmf_hdr_t   pkt_hdr,    // Packet header fields
  output logic [1:0]       match_hit   // Pair hits, one per pair
);

  // ----------------------------------------------------------------
  // Filter and control storage
  // ----------------------------------------------------------------
  // two pairs of match and mask
  logic [31:0] match_low_q  [NUM_PAIRS]; // Match words, low layout
  logic [31:0] match_low_d  [NUM_PAIRS];
  logic [31:0] match_high_q [NUM_PAIRS]; // Match words, high layout
  logic [31:0] match_high_d [NUM_PAIRS];
  logic [31:0] mask_low_q   [NUM_PAIRS]; // Mask words, low layout
  logic [31:0] mask_low_d   [NUM_PAIRS];
  logic [31:0] mask_high_q  [NUM_PAIRS]; // Mask words, high layout
  logic [31:0] mask_high_d  [NUM_PAIRS];
  logic [31:0] ctl_q        [NUM_CTR];   // Counter control words
  logic [31:0] ctl_d        [NUM_CTR];

  // Bus response registers
  logic [31:0] prdata_q;   // Read data to master
  logic [31:0] prdata_d;
  logic        pready_q;   // Ready, one cycle per access
  logic        pready_d;
  logic        pslverr_q;  // Unmapped access flag
  logic        pslverr_d;

  // Packet side registers
  logic [1:0]  match_hit_q; // Registered pair hits
  logic [1:0]  match_hit_d;
  logic [3:0]  last_flits_q; // Size of last serviced packet
  logic [3:0]  last_flits_d;

  // Combinational helpers
  logic        serviced;            // Packet crosses this cycle
  logic [1:0]  pair_hit;            // Raw pair comparator results
  logic        wr_commit;           // Write takes effect now
  logic        addr_ok;             // Address falls in the map
  logic [31:0] rd_word;             // Word at the address
  logic [NUM_CTR-1:0] ctr_clear;    // Per counter clear strobe
  logic [NUM_CTR-1:0] ctr_load_lo;  // Per counter low load
  logic [NUM_CTR-1:0] ctr_load_hi;  // Per counter high load
  logic [NUM_CTR-1:0] ctr_inc;      // Per counter increment
  logic [CTR_WIDTH-1:0] ctr_val [NUM_CTR]; // Counter values

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  // Byte address of a filter word in a given pair
  function automatic logic [7:0] pair_addr(input int p,
                                           input logic [7:0] off);
    return 8'(off + 8'(p) * PAIR_STRIDE);
  endfunction : pair_addr

  // Byte address of a counter data word
  function automatic logic [7:0] ctr_addr(input int c,
                                          input logic hi);
    return 8'(OFF_CTR_BASE + 8'(c) * CTR_STRIDE + (hi ? 8'h04 : 8'h00));
  endfunction : ctr_addr

  // ----------------------------------------------------------------
  // Packet path: serviced detection and comparison
  // ----------------------------------------------------------------
  // only accepted packets count
  assign serviced = pkt_valid && pkt_accept;

  // One comparator per pair
  for (genvar p = 0; p < NUM_PAIRS; p++)
  begin : g_pair
    lpmf_match u_match (
      .hdr        (pkt_hdr),
      .match_low  (match_low_q[p]),
      .match_high (match_high_q[p]),
      .mask_low   (mask_low_q[p]),
      .mask_high  (mask_high_q[p]),
      .hit        (pair_hit[p])
    );
  end

  // ----------------------------------------------------------------
  // Bus decode: read word and address check
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h0000_0000;
    addr_ok = 1'b0;
    // Unaligned addresses never map
    if ((paddr[1:0] == 2'h0) && (paddr < ADDR_LIMIT))
    begin
      for (int p = 0; p < NUM_PAIRS; p++)
      begin
        if (paddr == pair_addr(p, OFF_MATCH_LOW))
        begin
          rd_word = match_low_q[p];
          addr_ok = 1'b1;
        end
        if (paddr == pair_addr(p, OFF_MATCH_HIGH))
        begin
          rd_word = match_high_q[p];
          addr_ok = 1'b1;
        end
        if (paddr == pair_addr(p, OFF_MASK_LOW))
        begin
          rd_word = mask_low_q[p];
          addr_ok = 1'b1;
        end
        if (paddr == pair_addr(p, OFF_MASK_HIGH))
        begin
          rd_word = mask_high_q[p];
          addr_ok = 1'b1;
        end
      end
      for (int c = 0; c < NUM_CTR; c++)
      begin
        if (paddr == 8'(OFF_CTL_BASE + 8'(c) * 8'h04))
        begin
          // Clear bit is write only, reads zero
          rd_word = ctl_q[c];
          addr_ok = 1'b1;
        end
        if (paddr == ctr_addr(c, 1'b0))
        begin
          rd_word = ctr_val[c][31:0];
          addr_ok = 1'b1;
        end
        if (paddr == ctr_addr(c, 1'b1))
        begin
          rd_word = {16'h0000, ctr_val[c][CTR_WIDTH-1:32]};
          addr_ok = 1'b1;
        end
      end
      if (paddr == OFF_STATUS)
      begin
        rd_word = {26'h0, match_hit_q, last_flits_q};
        addr_ok = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus response: ready one cycle after the access phase starts
  // ----------------------------------------------------------------
  always_comb
  begin
    // Ready pulses for one cycle, then drops for the next transfer
    pready_d  = psel && penable && !pready_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d)
    begin
      prdata_d  = pwrite ? 32'h0000_0000 : rd_word;
      pslverr_d = !addr_ok;
    end
  end

  // Writes commit on the edge where ready is seen high
  assign wr_commit = psel && penable && pready_q && pwrite && addr_ok;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  always_comb
  begin
    match_low_d  = match_low_q;
    match_high_d = match_high_q;
    mask_low_d   = mask_low_q;
    mask_high_d  = mask_high_q;
    ctl_d        = ctl_q;
    ctr_clear    = '0;
    ctr_load_lo  = '0;
    ctr_load_hi  = '0;
    if (wr_commit)
    begin
      for (int p = 0; p < NUM_PAIRS; p++)
      begin
        if (paddr == pair_addr(p, OFF_MATCH_LOW))
          match_low_d[p] = pwdata & LOW_WR_MASK;
        if (paddr == pair_addr(p, OFF_MATCH_HIGH))
          match_high_d[p] = pwdata & HIGH_WR_MASK;
        if (paddr == pair_addr(p, OFF_MASK_LOW))
          mask_low_d[p] = pwdata & LOW_WR_MASK;
        if (paddr == pair_addr(p, OFF_MASK_HIGH))
          mask_high_d[p] = pwdata & HIGH_WR_MASK;
      end
      for (int c = 0; c < NUM_CTR; c++)
      begin
        if (paddr == 8'(OFF_CTL_BASE + 8'(c) * 8'h04))
        begin
          ctl_d[c] = pwdata & CTL_WR_MASK;
          // Clear acts now and is never stored
          ctr_clear[c] = pwdata[CTL_CLR_BIT];
        end
        ctr_load_lo[c] = (paddr == ctr_addr(c, 1'b0));
        ctr_load_hi[c] = (paddr == ctr_addr(c, 1'b1));
      end
    end
  end

  // ----------------------------------------------------------------
  // Packet side next values
  // ----------------------------------------------------------------
  always_comb
  begin
    match_hit_d  = serviced ? pair_hit : 2'h0;
    last_flits_d = last_flits_q;
    if (serviced)
      last_flits_d = packet_flits(pkt_hdr);
    for (int c = 0; c < NUM_CTR; c++)
    begin
      ctr_inc[c] = ctl_q[c][CTL_EN_BIT]
                   && (ctl_q[c][7:0] == EVSEL_FILTER_MATCH)
                   && serviced
                   && pair_hit[ctl_q[c][CTL_PAIR_BIT]];
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CTR; c++)
  begin : g_ctr
    lpmf_counter #(
      .WIDTH (CTR_WIDTH)
    ) u_ctr (
      .clk       (clk),
      .rst       (rst),
      .clear     (ctr_clear[c]),
      .load_low  (ctr_load_lo[c]),
      .load_high (ctr_load_hi[c]),
      .wdata     (pwdata),
      .inc       (ctr_inc[c]),
      .count_q   (ctr_val[c])
    );
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int p = 0; p < NUM_PAIRS; p++)
      begin
        match_low_q[p]  <= FILT_RESET;
        match_high_q[p] <= FILT_RESET;
        mask_low_q[p]   <= FILT_RESET;
        mask_high_q[p]  <= FILT_RESET;
      end
      for (int c = 0; c < NUM_CTR; c++)
        ctl_q[c] <= CTL_RESET;
      prdata_q     <= 32'h0000_0000;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
      match_hit_q  <= 2'h0;
      last_flits_q <= FLITS_UNKNOWN;
    end
    else
    begin
      match_low_q  <= match_low_d;
      match_high_q <= match_high_d;
      mask_low_q   <= mask_low_d;
      mask_high_q  <= mask_high_d;
      ctl_q        <= ctl_d;
      prdata_q     <= prdata_d;
      pready_q     <= pready_d;
      pslverr_q    <= pslverr_d;
      match_hit_q  <= match_hit_d;
      last_flits_q <= last_flits_d;
    end
  end

  // Outputs straight from flops
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign match_hit = match_hit_q;

endmodule : lpmf_top
`default_nettype wire

// ===== tb/lpmf_chk.sv
// Checker: port-level assertions for the packet filter
`timescale 1ns/10ps
`default_nettype none
module lpmf_chk
  import lpmf_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pkt_valid,
  input wire logic        pkt_accept,
  input wire logic [1:0]  match_hit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rdy_wait; psel && penable && !pready |=> pready; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready late");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready long");
  property p_rdy_req; pready |-> psel && penable; endproperty
  a_rdy_req: assert property (p_rdy_req) else $error("stray ready");
  property p_err; pready && (paddr >= ADDR_LIMIT || paddr[1:0] != 2'h0)
    |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok; pready && paddr < ADDR_LIMIT && paddr[1:0] == 2'h0
    |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("false error");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("lone error");
  property p_hit; match_hit != 2'h0 |-> $past(pkt_valid && pkt_accept);
  endproperty
  a_hit: assert property (p_hit) else $error("hit unserviced");
  property p_rst; $past(rst) |-> !pready && match_hit == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule : lpmf_chk
bind lpmf_top lpmf_chk lpmf_chk_i (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid),
  .pkt_accept(pkt_accept), .match_hit(match_hit));
`default_nettype wire

// ===== tb/lpmf_link_model.sv
// Link ports model: input port offers, output port accepts
`timescale 1ns/10ps
`default_nettype none
module lpmf_link_model
  import lpmf_pkg::*;
(
  input  wire logic       clk,        // Link clock
  input  wire logic       rst,        // Synchronous reset
  input  wire logic       snd,        // Offer a packet
  input  wire logic       acc,        // Output port takes it
  input  wire lpmf_hdr_t  hin,        // Header to offer
  output logic            pkt_valid,  // Header valid
  output logic            pkt_accept, // Serviced this cycle
  output lpmf_hdr_t       pkt_hdr     // Header lines
);
  always_ff @(posedge clk)
  begin
    pkt_valid  <= !rst && snd;
    pkt_accept <= !rst && snd && acc;
    // Idle lines toggle so a stale header cannot look valid
    pkt_hdr    <= rst ? '0 : (snd ? hin : ~pkt_hdr);
  end
endmodule : lpmf_link_model
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench: table of filter cases plus register and counter tests
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lpmf_pkg::*;
  typedef struct { logic [31:0] ml, mh, kl, kh; logic [23:0] h;
                   logic a, e; } lpmf_row_t;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, pkt_valid, pkt_accept, snd = 0, acc = 0;
  logic [1:0] match_hit;
  lpmf_hdr_t pkt_hdr, hin = '0;
  int fail_count = 0, num_checks = 0, hits = 0, h0;
  lpmf_row_t rows[15] = '{
    '{0, 0, 0, 0, 24'h0003A5, 1, 1}, '{0, 0, 0, 0, 24'h0003A5, 0, 0},
    '{32'h1C00, 0, 32'h1E00, 0, 24'h000380, 1, 1},
    '{32'h1C00, 0, 32'h1E00, 0, 24'h000100, 1, 0},
    '{32'hA000, 0, 32'h3E000, 0, 24'h001400, 1, 1},
    '{32'hA000, 0, 32'h3E000, 0, 24'h001000, 1, 0},
    '{32'h80000000, 3, 32'h80000000, 15, 24'h098000, 1, 1},
    '{32'h80000000, 3, 32'h80000000, 15, 24'h018000, 1, 0},
    '{32'h1C00, 32'h80000, 32'h1FE0, 32'hF0000, 24'h800380, 1, 1},
    '{32'h1C00, 32'h80000, 32'h1FE0, 32'hF0000, 24'h400380, 1, 0},
    '{32'h1C00, 32'h80000, 32'h1E00, 32'hF0000, 24'h40038C, 1, 1},
    '{32'h08, 0, 32'h18, 0, 24'h000001, 1, 1},
    '{32'h08, 0, 32'h18, 0, 24'h000002, 1, 0},
    '{32'h1D00, 0, 32'h1F00, 0, 24'h0003A0, 1, 1},
    '{32'h1D00, 0, 32'h1F00, 0, 24'h000380, 1, 0}};
  always #4 clk = ~clk;
  always @(posedge clk) if (match_hit[0] === 1'b1) hits <= hits + 1;
  lpmf_top lpmf_top_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_valid(pkt_valid), .pkt_accept(pkt_accept), .pkt_hdr(pkt_hdr),
    .match_hit(match_hit));
  lpmf_link_model lpmf_link_model_i (.clk(clk), .rst(rst), .snd(snd),
    .acc(acc), .hin(hin), .pkt_valid(pkt_valid),
    .pkt_accept(pkt_accept), .pkt_hdr(pkt_hdr));
  // Verdict and end of run
  task automatic results;
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Compare one value
  task automatic chk(input string n, input logic [31:0] x, y);
    num_checks++;
    if (x !== y)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, x, y);
    end
  endtask : chk
  // One APB transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 20)
    begin
      fail_count++;
      results();
    end
  endtask : apb
  // Offer n back-to-back packets
  task automatic pkt(input logic [23:0] h, input logic a, input int n);
    @(posedge clk);
    snd <= 1; acc <= a; hin <= h;
    repeat (n) @(posedge clk);
    snd <= 0;
    repeat (4) @(posedge clk);
  endtask : pkt
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 32; i += 4)
    begin
      apb(0, 8'(i), 0); chk("rst", 0, rd);
    end
    foreach (rows[i])
    begin
      apb(1, 8'h00, rows[i].ml); apb(1, 8'h04, rows[i].mh);
      apb(1, 8'h08, rows[i].kl); apb(1, 8'h0C, rows[i].kh);
      apb(1, 8'h20, 32'h0042_0038);
      h0 = hits;
      pkt(rows[i].h, rows[i].a, 1);
      apb(0, 8'h30, 0);
      chk("count", {31'h0, rows[i].e}, rd);
      chk("hit", {31'h0, rows[i].e}, hits - h0);
    end
    // Reserved bits kept at zero by software
    apb(1, 8'h04, 32'h000F_000F); apb(0, 8'h04, 0);
    chk("high", HIGH_WR_MASK, rd);
    apb(1, 8'h00, 32'h8003_FFF8); apb(0, 8'h00, 0);
    chk("low", LOW_WR_MASK, rd);
    apb(0, 8'h54, 0); chk("unmap", 32'h1, {31'h0, er});
    apb(0, 8'h02, 0); chk("unalign", 32'h1, {31'h0, er});
    // Pair one selected by bit 8, pair zero open
    apb(1, 8'h00, 0); apb(1, 8'h04, 0); apb(1, 8'h08, 0); apb(1, 8'h0C, 0);
    apb(1, 8'h10, 32'h1C00); apb(1, 8'h18, 32'h1E00);
    apb(1, 8'h20, 32'h0042_0138);
    pkt(24'h000100, 1, 1); apb(0, 8'h30, 0); chk("pair1", 0, rd);
    pkt(24'h000380, 1, 3); apb(0, 8'h30, 0); chk("b2b", 3, rd);
    // Other event code must not count
    apb(1, 8'h20, 32'h0042_0037);
    pkt(24'h000380, 1, 2); apb(0, 8'h30, 0); chk("evsel", 0, rd);
    // Wrap at 48 bits
    apb(1, 8'h20, 32'h0040_0038);
    apb(1, 8'h30, 32'hFFFFFFFF); apb(1, 8'h34, 32'h0000FFFF);
    pkt(24'h000380, 1, 1);
    apb(0, 8'h30, 0); chk("wrap_lo", 0, rd);
    apb(0, 8'h34, 0); chk("wrap_hi", 0, rd);
    // Size decode shown in the status word
    pkt(24'h0003A0, 1, 1); apb(0, 8'h50, 0);
    chk("flits_data", {28'h0, FLITS_PARTIAL}, rd);
    pkt(24'h000120, 1, 1); apb(0, 8'h50, 0);
    chk("flits_std", {28'h0, FLITS_STD_LONG}, rd);
    // Mid-run reset clears filters and counters
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    apb(0, 8'h10, 0); chk("rst_pair", 0, rd);
    apb(0, 8'h30, 0); chk("rst_ctr", 0, rd);
    results();
  end
endmodule : tb_top
`default_nettype wire
